/* File: design/barrier_map.svh */
// Offsets, widths and timing counts of the output data barrier.
`ifndef BARRIER_MAP_SVH
`define BARRIER_MAP_SVH
`define LIGHT_WIDTH       4
`define SWITCH_WIDTH      4
`define SW_BACKGROUND     0
`define SW_MEAS_CONTROL   1
`define SW_CALIBRATE      2
`define SW_MEASUREMENT    3
`define CLK_PERIOD_NS     8
`define FILTER_TIME_NS    1000
`define FILTER_CYCLES     ((`FILTER_TIME_NS) / (`CLK_PERIOD_NS))
`define FILTER_CNT_WIDTH  8
`endif

/* File: design/barrier_pkg.sv */
// Types of the output data barrier.
package barrier_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CYCLE = 2'b01
  } cycle_state_t;
endpackage

/* File: design/display_output_data_barrier.sv */
// Output data barrier: clocked light outputs, filtered status and switch word.
// Function
// - One output bit per pattern line; one lights a lamp, zero darkens it.
// - A one-hot trigger fires a one-shot, the only load of the pattern.
// - Output flip-flops load at most once per measurement cycle.
// - Pass/fail results reach the display only through clocked flip-flops.
// - Open and secure status bypass the flip-flops through low-pass filters.
// - Each optical driver is fed only by a flip-flop or a filter.
// - A switch press sets its own bit in the processor-readable word; of switches pressed together, only the lowest.
// - The word holds background, measurement control, calibrate, measurement bits.
// - Input path latches presses and rejects repeated pushes.
// - Once a cycle has begun, further switch closures are ignored.
`timescale 1ns/1ns
`include "barrier_map.svh"
module display_output_data_barrier #(
  parameter int LIGHT_W  = `LIGHT_WIDTH,
  parameter int SWITCH_W = `SWITCH_WIDTH
) (
  input  wire logic                I_CLK,
  input  wire logic                I_RST_N,
  input  wire logic [LIGHT_W-1:0]  I_PATTERN,
  input  wire logic [LIGHT_W-1:0]  I_TRIGGER,
  input  wire logic                I_CYCLE_DONE,
  input  wire logic                I_SYS_OPEN,
  input  wire logic                I_SYS_SECURE,
  input  wire logic [SWITCH_W-1:0] I_SWITCH,
  output logic      [LIGHT_W-1:0]  O_LIGHT,
  output logic                     O_OPEN_LIGHT,
  output logic                     O_SECURE_LIGHT,
  output logic      [SWITCH_W-1:0] O_SWITCH_WORD,
  output logic                     O_CYCLE_ACTIVE
);

  typedef struct packed {
    logic [LIGHT_W-1:0]            trig_s1;
    logic [LIGHT_W-1:0]            trig_s2;
    logic [LIGHT_W-1:0]            pat_s1;
    logic [LIGHT_W-1:0]            pat_s2;
    logic                          trig_prev;
    logic                          loaded;
    logic [LIGHT_W-1:0]            light;
    logic [1:0]                    open_s;
    logic [1:0]                    secure_s;
    logic [`FILTER_CNT_WIDTH-1:0]  open_cnt;
    logic [`FILTER_CNT_WIDTH-1:0]  secure_cnt;
    logic                          open_f;
    logic                          secure_f;
    logic [SWITCH_W-1:0]           sw_s1;
    logic [SWITCH_W-1:0]           sw_s2;
    logic [SWITCH_W-1:0]           word;
    logic [1:0]                    done_s;
    barrier_pkg::cycle_state_t     state;
  } state_t;

  localparam logic [`FILTER_CNT_WIDTH-1:0] FILT_MAX = `FILTER_CNT_WIDTH'(`FILTER_CYCLES);

  state_t s_q;
  state_t s_d;
  logic   one_hot;
  logic   fire;

  // The trigger counts only when exactly one bit is set.
  assign one_hot = (s_q.trig_s2 != '0) && ((s_q.trig_s2 & (s_q.trig_s2 - 1'b1)) == '0);
  assign fire    = one_hot && !s_q.trig_prev;

  always_comb begin
    s_d           = s_q;
    s_d.trig_s1   = I_TRIGGER;
    s_d.trig_s2   = s_q.trig_s1;
    s_d.trig_prev = one_hot;
    // The pattern passes the same two stages as the trigger, so both stay aligned.
    s_d.pat_s1    = I_PATTERN;
    s_d.pat_s2    = s_q.pat_s1;
    s_d.open_s    = {s_q.open_s[0], I_SYS_OPEN};
    s_d.secure_s  = {s_q.secure_s[0], I_SYS_SECURE};
    s_d.sw_s1     = I_SWITCH;
    s_d.sw_s2     = s_q.sw_s1;
    s_d.done_s    = {s_q.done_s[0], I_CYCLE_DONE};
    // The pattern is sampled only on the one-shot edge, once per cycle.
    if (fire && !s_q.loaded) begin
      s_d.light  = s_q.pat_s2;
      s_d.loaded = 1'b1;
    end
    // Status levels pass only after holding steady for the filter time.
    if (s_q.open_s[1] == s_q.open_f) begin
      s_d.open_cnt = '0;
    end else if (s_q.open_cnt == FILT_MAX) begin
      s_d.open_f   = s_q.open_s[1];
      s_d.open_cnt = '0;
    end else begin
      s_d.open_cnt = s_q.open_cnt + 1'b1;
    end
    if (s_q.secure_s[1] == s_q.secure_f) begin
      s_d.secure_cnt = '0;
    end else if (s_q.secure_cnt == FILT_MAX) begin
      s_d.secure_f   = s_q.secure_s[1];
      s_d.secure_cnt = '0;
    end else begin
      s_d.secure_cnt = s_q.secure_cnt + 1'b1;
    end
    case (s_q.state)
      barrier_pkg::ST_IDLE: begin
        if (s_q.sw_s2 != '0) begin
          // Only the lowest pressed switch is latched, one bit per switch.
          s_d.word  = s_q.sw_s2 & (~s_q.sw_s2 + 1'b1);
          s_d.state = barrier_pkg::ST_CYCLE;
        end
      end
      barrier_pkg::ST_CYCLE: begin
        // Presses are ignored until the processor ends the cycle.
        if (s_q.done_s[1]) begin
          s_d.word   = '0;
          s_d.loaded = fire && !s_q.loaded;
          s_d.state  = barrier_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.state = barrier_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Drivers see only flip-flops or filters; no display signal comes back.
  assign O_LIGHT        = s_q.light;
  assign O_OPEN_LIGHT   = s_q.open_f;
  assign O_SECURE_LIGHT = s_q.secure_f;
  assign O_SWITCH_WORD  = s_q.word;
  assign O_CYCLE_ACTIVE = (s_q.state == barrier_pkg::ST_CYCLE);

  a_load_once: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_q.loaded && !s_q.done_s[1] |=> $stable(O_LIGHT))
    else $error("Lights changed twice in one cycle.");

  a_load_pattern: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    fire && !s_q.loaded |=> O_LIGHT == $past(s_q.pat_s2))
    else $error("Triggered load did not take the pattern.");

  a_light_cause: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !(fire && !s_q.loaded) |=> $stable(O_LIGHT))
    else $error("Lights changed without a trigger.");

  a_open_filter: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $changed(O_OPEN_LIGHT) |-> $past(s_q.open_cnt) == FILT_MAX)
    else $error("Open light changed before the filter time.");

  a_secure_filter: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $changed(O_SECURE_LIGHT) |-> $past(s_q.secure_cnt) == FILT_MAX)
    else $error("Secure light changed before the filter time.");

  a_switch_onehot: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $onehot0(O_SWITCH_WORD) && (O_CYCLE_ACTIVE == (O_SWITCH_WORD != '0)))
    else $error("Switch word not a single bit.");

  a_press_latch: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !O_CYCLE_ACTIVE && s_q.sw_s2 != '0 |=> O_CYCLE_ACTIVE ##0 O_SWITCH_WORD != '0)
    else $error("Switch press was not latched.");

  a_ignore_press: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_CYCLE_ACTIVE && !s_q.done_s[1] |=> $stable(O_SWITCH_WORD))
    else $error("Switch word changed during a cycle.");

  a_reset_dark: assert property (@(posedge I_CLK)
    !I_RST_N |=> O_LIGHT == '0 && O_SWITCH_WORD == '0)
    else $error("Reset did not clear the outputs.");

  a_trig_refused: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !$onehot(s_q.trig_s2) |=> $stable(O_LIGHT))
    else $error("Lights loaded without a one-hot trigger.");

  a_fire_single: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    fire |=> !fire)
    else $error("One-shot fired on two edges in a row.");

  a_load_rearm: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_CYCLE_ACTIVE && s_q.done_s[1] && !(fire && !s_q.loaded) |=> !s_q.loaded)
    else $error("Load was not re-armed at the end of a cycle.");

  a_cycle_end: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_CYCLE_ACTIVE && s_q.done_s[1] |=> !O_CYCLE_ACTIVE && O_SWITCH_WORD == '0)
    else $error("Cycle did not end on the done level.");

  a_press_lowest: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !O_CYCLE_ACTIVE && s_q.sw_s2 != '0 |=> (O_SWITCH_WORD & $past(s_q.sw_s2)) != '0 &&
    ($past(s_q.sw_s2) & (O_SWITCH_WORD - 1'b1)) == '0)
    else $error("Latched switch is not the lowest pressed one.");

  a_open_follow: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_q.open_s[1] != O_OPEN_LIGHT && s_q.open_cnt == FILT_MAX |=>
    O_OPEN_LIGHT == $past(s_q.open_s[1]))
    else $error("Open light did not follow a steady level.");

  a_secure_follow: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_q.secure_s[1] != O_SECURE_LIGHT && s_q.secure_cnt == FILT_MAX |=>
    O_SECURE_LIGHT == $past(s_q.secure_s[1]))
    else $error("Secure light did not follow a steady level.");

  a_open_glitch: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_q.open_s[1] == O_OPEN_LIGHT |=> s_q.open_cnt == '0)
    else $error("Open filter kept counting after a glitch.");

  a_secure_glitch: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_q.secure_s[1] == O_SECURE_LIGHT |=> s_q.secure_cnt == '0)
    else $error("Secure filter kept counting after a glitch.");

  a_open_bound: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_q.open_cnt <= FILT_MAX)
    else $error("Open filter count ran past its limit.");

  a_secure_bound: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_q.secure_cnt <= FILT_MAX)
    else $error("Secure filter count ran past its limit.");

endmodule

/* File: tb/proc_model.sv */
// Processor-side model that presents a light pattern and fires a one-hot trigger.
`timescale 1ns/1ns
module proc_model (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [3:0] i_pat,
  output logic      [3:0] o_pattern,
  output logic      [3:0] o_trigger
);
  initial begin
    o_pattern = 4'h0;
    o_trigger = 4'h0;
    forever begin
      do begin
        @(negedge i_clk);
      end while (!i_go);
      o_pattern <= i_pat;
      repeat (2) @(negedge i_clk);
      o_trigger <= 4'h1;
      repeat (4) @(negedge i_clk);
      o_trigger <= 4'h0;
      repeat (4) @(negedge i_clk);
      o_pattern <= ~i_pat;
    end
  end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench of the output data barrier.
`timescale 1ns/1ns
module testbench;
  logic        I_CLK = 0, I_RST_N = 0, I_CYCLE_DONE = 0, I_SYS_OPEN = 0, I_SYS_SECURE = 0;
  logic        go = 0, O_OPEN_LIGHT, O_SECURE_LIGHT, O_CYCLE_ACTIVE;
  logic [3:0]  I_SWITCH = 4'h0, pat = 4'h0, I_PATTERN, I_TRIGGER, O_LIGHT, O_SWITCH_WORD;
  logic [15:0] rnd = 16'hB7F1;
  logic [7:0]  q[$];
  int          bad_count = 0;
  int          comparisons = 0;
  wire  [15:0] obs = {2'h0, O_SECURE_LIGHT, O_OPEN_LIGHT, 3'h0, O_CYCLE_ACTIVE,
                      O_SWITCH_WORD, O_LIGHT};
  initial forever #4 I_CLK = ~I_CLK;
  display_output_data_barrier i_dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_PATTERN(I_PATTERN), .I_TRIGGER(I_TRIGGER), .I_CYCLE_DONE(I_CYCLE_DONE),
    .I_SYS_OPEN(I_SYS_OPEN), .I_SYS_SECURE(I_SYS_SECURE), .I_SWITCH(I_SWITCH),
    .O_LIGHT(O_LIGHT), .O_OPEN_LIGHT(O_OPEN_LIGHT), .O_SECURE_LIGHT(O_SECURE_LIGHT),
    .O_SWITCH_WORD(O_SWITCH_WORD), .O_CYCLE_ACTIVE(O_CYCLE_ACTIVE));
  proc_model i_proc (.i_clk(I_CLK), .i_go(go), .i_pat(pat), .o_pattern(I_PATTERN),
    .o_trigger(I_TRIGGER));
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(logic [3:0] s, logic [3:0] e, logic [3:0] v);
    comparisons++;
    if (v !== e) begin
      bad_count++;
      $display("ERROR out%0d expected %h seen %h", s, e, v);
    end
  endtask
  task automatic note(logic [3:0] s, logic [3:0] e);
    q.push_back({s, e});
  endtask
  always @(negedge I_CLK) begin
    while (q.size() > 0) begin
      check(q[0][7:4], q[0][3:0], obs[q[0][7:4]*4 +: 4]);
      void'(q.pop_front());
    end
  end
  task automatic load(logic [3:0] p);
    pat <= p;
    go <= 1'b1;
    @(negedge I_CLK);
    go <= 1'b0;
    repeat (12) @(negedge I_CLK);
  endtask
  task automatic finish_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (10) @(negedge I_CLK);
    I_RST_N <= 1'b1;
    @(negedge I_CLK);
    note(4'h0, 4'h0);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      I_SWITCH <= (4'h1 << i) | 4'h8;
      repeat (5) @(negedge I_CLK);
      I_SWITCH <= ~(4'h1 << i);
      load(rnd[3:0]);
      note(4'h1, 4'h1 << i);
      note(4'h2, 4'h1);
      note(4'h0, rnd[3:0]);
      load(~rnd[3:0]);
      note(4'h0, rnd[3:0]);
      I_SWITCH <= 4'h0;
      I_CYCLE_DONE <= 1'b1;
      repeat (5) @(negedge I_CLK);
      note(4'h1, 4'h0);
      I_CYCLE_DONE <= 1'b0;
      repeat (3) @(negedge I_CLK);
    end
    I_SYS_OPEN <= 1'b1;
    repeat (20) @(negedge I_CLK);
    I_SYS_OPEN <= 1'b0;
    repeat (150) @(negedge I_CLK);
    note(4'h3, 4'h0);
    I_SYS_OPEN <= 1'b1;
    repeat (60) @(negedge I_CLK);
    note(4'h3, 4'h0);
    repeat (100) @(negedge I_CLK);
    note(4'h3, 4'h1);
    I_SYS_OPEN <= 1'b0;
    I_SYS_SECURE <= 1'b1;
    repeat (160) @(negedge I_CLK);
    note(4'h3, 4'h2);
    repeat (2) @(negedge I_CLK);
    finish_test();
  end
endmodule
